/* arsv_client_model.sv */
`timescale 1ns/10ps
// Client stand-in: launches its requests from flops and captures the flag.
module arsv_client_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic rdReq,
  input wire logic [1:0] opMode,
  input wire logic [7:0] statusHi,
  input wire logic anDone,
  output logic statusRegRead,
  output logic faultSeen,
  output logic [7:0] trustedHi
);
  // Registered both ways, so no device path meets client logic directly.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      statusRegRead <= 1'b0;
      faultSeen <= 1'b0;
      trustedHi <= 8'h00;
    end else begin
      statusRegRead <= rdReq;
      // The flag has no meaning on the PHY side, so it is dropped there.
      faultSeen <= statusHi[arsv_pkg::RF_FLAG_BIT - 8] && (opMode != 2'h2);
      // SGMII results are only taken once negotiation has completed.
      if (opMode == 2'h0 || opMode == 2'h3 || anDone) begin
        trustedHi <= statusHi;
      end
    end
  end
endmodule : arsv_client_model

/* arsv_pkg.sv */
package arsv_pkg;

  // Operating standard selected for the core.
  typedef enum logic [1:0] {
    ARSV_BASEX,
    ARSV_SGMII_MAC,
    ARSV_SGMII_PHY
  } arsv_mode_t;

  // Status word layout for the upper half.
  localparam int RF_TYPE_LO = 8;
  localparam int RF_TYPE_HI = 9;
  localparam int SPEED_LO = 10;
  localparam int SPEED_HI = 11;
  localparam int DUPLEX_BIT = 12;
  localparam int RF_FLAG_BIT = 13;
  localparam int PAUSE_LO = 14;
  localparam int PAUSE_HI = 15;

  // Link-partner base page field positions.
  localparam int LP_PAUSE_LO = 7;
  localparam int LP_PAUSE_HI = 8;
  localparam int LP_DUPLEX_X = 5;
  localparam int LP_SPEED_LO = 10;
  localparam int LP_SPEED_HI = 11;
  localparam int LP_DUPLEX_S = 12;
  localparam int LP_RF_LO = 12;
  localparam int LP_RF_HI = 13;
  localparam int LP_LINK = 15;

  // Advertisement register speed field positions.
  localparam int ADV_SPEED_LO = 10;
  localparam int ADV_SPEED_HI = 11;

  // Encodings.
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] RF_NONE = 2'h0;
  localparam logic [1:0] RF_LINK_FAIL = 2'h2;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // Interrupt register layout: bit 0 remote fault seen, bit 1 results changed.
  localparam logic [1:0] ADDR_IRQ_STAT = 2'h0;
  localparam logic [1:0] ADDR_IRQ_MASK = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam int IRQ_RF = 0;
  localparam int IRQ_CHG = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

endpackage : arsv_pkg

/* arsv_status_hi.sv */
`timescale 1ns/10ps
// Summary of operation
// [RL1] Remote fault type on bits nine to eight.
// [RL2] 1000BASE-X fault type from partner bits 13:12.
// [RL3] SGMII PHY side fault type held 00.
// [RL4] SGMII MAC side: type 10 when link low.
// [RL5] Speed bits 11:10; BASE-X fixed at 10.
// [RL6] SGMII speed from partner or advertisement.
// [RL7] Speed codes: 10 gig, 01 hundred, 00 ten.
// [RL8] Duplex bit 12 from partner bit 5 or 12.
// [RL9] Duplex one full, zero half.
// [RL10] Bit 13 flags a detected remote fault.
// [RL11] Fault flag sticky until status register read.
// [RL12] Client ignores flag in PHY or no management; the client model drops it in PHY mode (opMode 2) only.
// [RL13] Pause bits 15:14 from partner bits 8:7.
// [RL14] Pause codes none, symmetric, asymmetric, both.
// [RL15] Client registers all signals to and from device.
// [RL16] Client trusts SGMII results after negotiation completes.
// [RL17] Synchronous update, zero while in reset.
module arsv_status_hi (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [1:0] opMode,
  input wire logic [15:0] lpBasePage,
  input wire logic [15:0] advAbility,
  input wire logic remoteFaultEvt,
  input wire logic statusRegRead,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  output logic [7:0] statusHi,
  output logic irq
);

  // Mode decoded from the configuration input; an illegal code falls back to BASE-X.
  arsv_pkg::arsv_mode_t mode;
  // Next value of the derived result fields, with the sticky flag copied in.
  logic [7:0] next_statusHi;
  // Sticky remote fault flag, kept in its own flip-flop.
  logic faultFlag;
  // Sticky interrupt status and mask.
  logic [1:0] irqStat;
  logic [1:0] irqMask;
  // Events that feed the interrupt status.
  logic [1:0] irqEvt;

  // The block keeps no copy of the management registers. It only watches the
  // partner base page and the local advertisement as levels and re-derives
  // every result field on each enabled edge. Those levels may change at any time.
  // The status word therefore follows them with one cycle of latency and never
  // holds a stale field once the inputs have settled.
  // The price is that a glitch on a source register shows up for one cycle.
  // The client is expected to qualify the results with its own completion flag.
  // Mode code three is not a real configuration; it is read as BASE-X.
  // That keeps the speed field at the gigabit code instead of a random value.
  // Decode the mode input into the enumerated type.
  always_comb begin
    unique case (opMode)
      2'h1: mode = arsv_pkg::ARSV_SGMII_MAC;
      2'h2: mode = arsv_pkg::ARSV_SGMII_PHY;
      default: mode = arsv_pkg::ARSV_BASEX;
    endcase
  end

  // Select each field from its source for the present mode.
  // The word is cleared first, so no field can keep a value from an older mode.
  // Indices are taken from the full status word, so eight is removed from each.
  // The sticky flag is not derived here; it is copied from its own flip-flop.
  always_comb begin
    next_statusHi = arsv_pkg::STAT_RESET;
    // Pause is copied in every mode; it only carries meaning in BASE-X.
    next_statusHi[arsv_pkg::PAUSE_HI - 8 -: 2] =
      lpBasePage[arsv_pkg::LP_PAUSE_HI:arsv_pkg::LP_PAUSE_LO]; // RL13 RL14
    next_statusHi[arsv_pkg::RF_FLAG_BIT - 8] = faultFlag; // RL10
    unique case (mode)
      arsv_pkg::ARSV_SGMII_MAC: begin
        // A dropped partner link is the only fault the MAC side can report.
        next_statusHi[arsv_pkg::RF_TYPE_HI - 8 -: 2] =
          lpBasePage[arsv_pkg::LP_LINK] ? arsv_pkg::RF_NONE : arsv_pkg::RF_LINK_FAIL; // RL4
        next_statusHi[arsv_pkg::SPEED_HI - 8 -: 2] =
          lpBasePage[arsv_pkg::LP_SPEED_HI:arsv_pkg::LP_SPEED_LO]; // RL6 RL7
        next_statusHi[arsv_pkg::DUPLEX_BIT - 8] = lpBasePage[arsv_pkg::LP_DUPLEX_S]; // RL8 RL9
      end
      arsv_pkg::ARSV_SGMII_PHY: begin
        // The PHY side has no fault type to show.
        next_statusHi[arsv_pkg::RF_TYPE_HI - 8 -: 2] = arsv_pkg::RF_NONE; // RL3
        next_statusHi[arsv_pkg::SPEED_HI - 8 -: 2] =
          advAbility[arsv_pkg::ADV_SPEED_HI:arsv_pkg::ADV_SPEED_LO]; // RL6 RL7
        next_statusHi[arsv_pkg::DUPLEX_BIT - 8] = lpBasePage[arsv_pkg::LP_DUPLEX_S]; // RL8 RL9
      end
      arsv_pkg::ARSV_BASEX: begin
        next_statusHi[arsv_pkg::RF_TYPE_HI - 8 -: 2] =
          lpBasePage[arsv_pkg::LP_RF_HI:arsv_pkg::LP_RF_LO]; // RL1 RL2
        // Speed is hard wired here; mode code three reads the same code.
        next_statusHi[arsv_pkg::SPEED_HI - 8 -: 2] = arsv_pkg::SPEED_1000; // RL5
        next_statusHi[arsv_pkg::DUPLEX_BIT - 8] = lpBasePage[arsv_pkg::LP_DUPLEX_X]; // RL8 RL9
      end
    endcase
  end

  // Sticky fault flag; a new fault in the read cycle wins over the clear.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      faultFlag <= 1'b0; // RL17
    end else if (clkEn) begin
      if (remoteFaultEvt) begin
        faultFlag <= 1'b1; // RL10 RL11
      end else if (statusRegRead) begin
        faultFlag <= 1'b0; // RL11
      end
    end
  end

  // Register the status word so every output leaves a flip-flop.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      statusHi <= arsv_pkg::STAT_RESET; // RL17
    end else if (clkEn) begin
      statusHi <= next_statusHi; // RL17
    end
  end

  // Events: a fault flag rising, or any result field changing.
  // The change event compares the next word with the registered one.
  // It fires once per change, on the edge that loads the new word.
  // A fault event seen while the clock enable is low is lost; a field change is taken once the enable returns.
  assign irqEvt[arsv_pkg::IRQ_RF] = next_statusHi[arsv_pkg::RF_FLAG_BIT - 8]
    & ~statusHi[arsv_pkg::RF_FLAG_BIT - 8];
  assign irqEvt[arsv_pkg::IRQ_CHG] = (next_statusHi != statusHi);

  // Interrupt status: set by events, cleared by writing one; set wins.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqStat <= arsv_pkg::IRQ_RESET;
    end else if (clkEn) begin
      if (regWrStb && regAddr == arsv_pkg::ADDR_IRQ_STAT) begin
        irqStat <= (irqStat & ~regWrData[1:0]) | irqEvt;
      end else begin
        irqStat <= irqStat | irqEvt;
      end
    end
  end

  // Interrupt mask register, a one enables the bit.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqMask <= arsv_pkg::IRQ_RESET;
    end else if (clkEn && regWrStb && regAddr == arsv_pkg::ADDR_IRQ_MASK) begin
      irqMask <= regWrData[1:0];
    end
  end

  // Interrupt output is registered, so it trails the status by one cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else if (clkEn) begin
      irq <= |(irqStat & irqMask);
    end
  end

  // Read data stands in the cycle after the strobe and reads zero otherwise.
  // Returning zero outside a read keeps a shared read bus free of stale data.
  // The status register reads the registered word, not the next value.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (clkEn) begin
      regRdData <= 8'h00;
      if (regRdStb) begin
        unique case (regAddr)
          arsv_pkg::ADDR_IRQ_STAT: regRdData <= {6'h00, irqStat};
          arsv_pkg::ADDR_IRQ_MASK: regRdData <= {6'h00, irqMask};
          arsv_pkg::ADDR_STATUS: regRdData <= statusHi;
          default: regRdData <= 8'h00;
        endcase
      end
    end
  end

  // BASE-X speed stays at the gigabit code one cycle after the mode holds.
  speed_fixed_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && mode == arsv_pkg::ARSV_BASEX) |=> (statusHi[3:2] == 2'h2)) // RL5
    else $error("speed not fixed in basex");

  // PHY side shows no fault type.
  phy_rftype_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && mode == arsv_pkg::ARSV_SGMII_PHY) |=> (statusHi[1:0] == 2'h0)) // RL3
    else $error("phy fault type not zero");

  // MAC side with link down shows type 10.
  mac_rftype_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && mode == arsv_pkg::ARSV_SGMII_MAC && !lpBasePage[15])
      |=> (statusHi[1:0] == 2'h2)) // RL4
    else $error("mac fault type wrong");

  // BASE-X fault type follows partner bits 13:12.
  basex_rftype_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && mode == arsv_pkg::ARSV_BASEX)
      |=> (statusHi[1:0] == $past(lpBasePage[13:12]))) // RL2
    else $error("basex fault type wrong");

  // Speed in PHY mode follows the advertisement register.
  phy_speed_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && mode == arsv_pkg::ARSV_SGMII_PHY)
      |=> (statusHi[3:2] == $past(advAbility[11:10]))) // RL6
    else $error("phy speed wrong");

  // Duplex in BASE-X follows partner bit 5.
  basex_duplex_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && mode == arsv_pkg::ARSV_BASEX)
      |=> (statusHi[4] == $past(lpBasePage[5]))) // RL8
    else $error("basex duplex wrong");

  // Pause follows partner bits 8:7.
  pause_copy_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn |=> (statusHi[7:6] == $past(lpBasePage[8:7]))) // RL13
    else $error("pause field wrong");

  // Fault flag holds without a read.
  fault_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (faultFlag && !statusRegRead) |=> faultFlag) // RL11
    else $error("fault flag dropped without read");

  // A fault event reaches status bit 13 two cycles later.
  fault_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && remoteFaultEvt) ##1 clkEn |=> statusHi[5]) // RL10
    else $error("fault flag not shown");

  // Reset clears the status word.
  reset_zero_a: assert property (@(posedge mclk)
    sys_rst |=> (statusHi == 8'h00 && !faultFlag)) // RL17
    else $error("status not zero after reset");

  // The checks below cover the remaining mode paths and the register port.
  // Each one checks a registered value one edge after the cycle that triggers it.
  // They are disabled in reset, where the reset check above takes over.

  // Speed in MAC mode follows partner bits 11:10.
  mac_speed_a: assert property (@(posedge mclk) disable iff (sys_rst) // RL6
    (clkEn && mode == arsv_pkg::ARSV_SGMII_MAC)
      |=> (statusHi[3:2] == $past(lpBasePage[11:10])))
    else $error("mac speed wrong");

  // Duplex in MAC mode follows partner bit 12.
  mac_duplex_a: assert property (@(posedge mclk) disable iff (sys_rst) // RL8
    (clkEn && mode == arsv_pkg::ARSV_SGMII_MAC)
      |=> (statusHi[4] == $past(lpBasePage[12])))
    else $error("mac duplex wrong");

  // Duplex in PHY mode follows partner bit 12.
  phy_duplex_a: assert property (@(posedge mclk) disable iff (sys_rst) // RL8
    (clkEn && mode == arsv_pkg::ARSV_SGMII_PHY)
      |=> (statusHi[4] == $past(lpBasePage[12])))
    else $error("phy duplex wrong");

  // MAC side with link up shows no fault type.
  mac_link_up_a: assert property (@(posedge mclk) disable iff (sys_rst) // RL4
    (clkEn && mode == arsv_pkg::ARSV_SGMII_MAC && lpBasePage[15])
      |=> (statusHi[1:0] == 2'h0))
    else $error("mac fault type not zero");

  // A read without a new fault clears the flag.
  flag_clear_a: assert property (@(posedge mclk) disable iff (sys_rst) // RL11
    (clkEn && statusRegRead && !remoteFaultEvt)
      |=> !faultFlag)
    else $error("fault flag not cleared by read");

  // A fault event sets the flag even beside a read.
  flag_set_a: assert property (@(posedge mclk) disable iff (sys_rst) // RL11
    (clkEn && remoteFaultEvt)
      |=> faultFlag)
    else $error("fault flag not set");

  // Status bit 13 mirrors the sticky flag one cycle later.
  flag_mirror_a: assert property (@(posedge mclk) disable iff (sys_rst) // RL10
    clkEn
      |=> (statusHi[5] == $past(faultFlag)))
    else $error("fault flag not mirrored");

  // A low clock enable freezes the status word, the interrupt and the flag.
  frozen_state_a: assert property (@(posedge mclk) disable iff (sys_rst) // RL17
    !clkEn
      |=> ($stable(statusHi) && $stable(faultFlag) && $stable(irq)))
    else $error("state moved while frozen");

  // The interrupt follows the unmasked status one cycle later.
  irq_level_a: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn
      |=> (irq == $past(|(irqStat & irqMask))))
    else $error("irq level wrong");

  // Read data is zero outside the cycle after a read.
  rd_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && !regRdStb)
      |=> (regRdData == 8'h00))
    else $error("read data not idle");

  // A status read returns the registered status word.
  rd_status_a: assert property (@(posedge mclk) disable iff (sys_rst) // RL10
    (clkEn && regRdStb && regAddr == arsv_pkg::ADDR_STATUS)
      |=> (regRdData == $past(statusHi)))
    else $error("status read data wrong");

  // A mask write lands in the mask register.
  mask_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && regWrStb && regAddr == arsv_pkg::ADDR_IRQ_MASK)
      |=> (irqMask == $past(regWrData[1:0])))
    else $error("mask write lost");

  // A fault event sets its interrupt bit, even beside a clear.
  irq_set_wins_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && irqEvt[0])
      |=> irqStat[0])
    else $error("fault irq not set");

  // Writing a one clears the fault interrupt bit when no event competes.
  irq_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && regWrStb && regAddr == arsv_pkg::ADDR_IRQ_STAT && regWrData[0] && !irqEvt[0])
      |=> !irqStat[0])
    else $error("fault irq not cleared");

  // A change of any result field sets the change interrupt bit.
  irq_change_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (clkEn && irqEvt[1])
      |=> irqStat[1])
    else $error("change irq not set");

endmodule : arsv_status_hi

/* arsv_status_hi_tb.sv */
`timescale 1ns/10ps
module arsv_status_hi_tb;
  typedef struct packed {logic [1:0] m; logic [15:0] lp; logic [15:0] adv;} arsv_row_t;
  logic mclk, sys_rst, clkEn, remoteFaultEvt, regWrStb, regRdStb, irq, statusRegRead;
  logic rdReq, faultSeen, anDone;
  logic [1:0] opMode, regAddr;
  logic [15:0] lpBasePage, advAbility;
  logic [7:0] regWrData, regRdData, statusHi, d, hold, trustedHi;
  int num_errors, total_checks, cycles;
  // Rows cover every mode, every speed code and every pause code.
  arsv_row_t rows [8] = '{'{2'h0, 16'h3180, 16'h0}, '{2'h0, 16'h1020, 16'h0},
    '{2'h3, 16'h2100, 16'h0}, '{2'h0, 16'h0080, 16'h0}, '{2'h1, 16'h1C00, 16'h0},
    '{2'h1, 16'h0400, 16'h0}, '{2'h2, 16'h9000, 16'h0800}, '{2'h2, 16'h3000, 16'h0}};
  arsv_status_hi arsv_status_hi_inst (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
    .opMode(opMode), .lpBasePage(lpBasePage), .advAbility(advAbility),
    .remoteFaultEvt(remoteFaultEvt), .statusRegRead(statusRegRead), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .statusHi(statusHi), .irq(irq));
  arsv_client_model arsv_client_model_inst (.mclk(mclk), .sys_rst(sys_rst), .rdReq(rdReq),
    .opMode(opMode), .statusHi(statusHi), .anDone(anDone), .statusRegRead(statusRegRead),
    .faultSeen(faultSeen), .trustedHi(trustedHi));
  // Expected upper status word; a MAC-side row always has the link bit low.
  function automatic logic [7:0] expect_hi(arsv_row_t r);
    logic [1:0] rf, sp;
    logic dup;
    {rf, sp, dup} = {r.lp[13:12], arsv_pkg::SPEED_1000, r.lp[5]};
    if (r.m == 2'h1) {rf, sp, dup} = {arsv_pkg::RF_LINK_FAIL, r.lp[11:10], r.lp[12]};
    if (r.m == 2'h2) {rf, sp, dup} = {arsv_pkg::RF_NONE, r.adv[11:10], r.lp[12]};
    return {r.lp[8:7], 1'b0, dup, sp, rf};
  endfunction : expect_hi
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk
  // Fields stand until inputs move, so three edges is ample settling time.
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk) {regAddr, regWrData, regWrStb} <= {a, v, 1'b1};
    @(posedge mclk) regWrStb <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge mclk) {regAddr, regRdStb} <= {a, 1'b1};
    @(posedge mclk) regRdStb <= 1'b0;
    #1 v = regRdData;
  endtask : rd
  task automatic pulse_req();
    @(posedge mclk) rdReq <= 1'b1;
    @(posedge mclk) rdReq <= 1'b0;
  endtask : pulse_req
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // A hang counts as a mismatch and goes straight to the report.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    {sys_rst, clkEn, opMode, lpBasePage, advAbility, remoteFaultEvt} = {2'b11, 35'h0};
    {regAddr, regWrData, regWrStb, regRdStb, rdReq, anDone} = 14'h0;
    {num_errors, total_checks, cycles} = '0;
    repeat (4) @(posedge mclk);
    #1 chk(statusHi, arsv_pkg::STAT_RESET, "reset status");
    chk({7'h0, irq}, 8'h00, "reset irq");
    @(posedge mclk) sys_rst <= 1'b0;
    foreach (rows[i]) begin
      @(posedge mclk) {opMode, lpBasePage, advAbility} <= rows[i];
      settle();
      chk(statusHi, expect_hi(rows[i]), "row");
    end
    chk(trustedHi, expect_hi(rows[3]), "sgmii untrusted");
    $display("Table rows done");
    @(posedge mclk) {opMode, lpBasePage, advAbility} <= {2'h0, 16'h2000, 16'h0};
    @(posedge mclk) remoteFaultEvt <= 1'b1;
    @(posedge mclk) remoteFaultEvt <= 1'b0;
    repeat (4) settle();
    chk(statusHi, expect_hi({2'h0, 16'h2000, 16'h0}) | 8'h20, "flag sticky");
    chk({7'h0, faultSeen}, 8'h01, "client flag");
    rd(arsv_pkg::ADDR_STATUS, d);
    chk(d, 8'h2A, "status read");
    pulse_req();
    // The second read request meets a new fault in the same design cycle.
    @(posedge mclk) rdReq <= 1'b1;
    @(posedge mclk) {rdReq, remoteFaultEvt} <= 2'b01;
    @(posedge mclk) remoteFaultEvt <= 1'b0;
    settle();
    chk(statusHi, 8'h2A, "set wins");
    pulse_req();
    settle();
    chk(statusHi, 8'h0A, "flag cleared");
    $display("Fault flag done");
    rd(arsv_pkg::ADDR_IRQ_STAT, d);
    chk(d, 8'h03, "irq status");
    chk({7'h0, irq}, 8'h00, "masked irq");
    wr(arsv_pkg::ADDR_IRQ_MASK, 8'h01);
    settle();
    chk({7'h0, irq}, 8'h01, "irq raised");
    wr(arsv_pkg::ADDR_IRQ_STAT, 8'h01);
    settle();
    chk({7'h0, irq}, 8'h00, "irq cleared");
    rd(arsv_pkg::ADDR_IRQ_STAT, d);
    chk(d, 8'h02, "w1c status");
    rd(arsv_pkg::ADDR_IRQ_MASK, d);
    chk(d, 8'h01, "mask readback");
    wr(2'h3, 8'hFF);
    rd(2'h3, d);
    chk(d, 8'h00, "unmapped read");
    $display("Registers done");
    hold = statusHi;
    @(posedge mclk) {clkEn, lpBasePage} <= {1'b0, 16'h0180};
    settle();
    chk(statusHi, hold, "frozen");
    @(posedge mclk) clkEn <= 1'b1;
    settle();
    chk(statusHi, 8'hC8, "resumed");
    @(posedge mclk) sys_rst <= 1'b1;
    settle();
    chk(statusHi, arsv_pkg::STAT_RESET, "mid reset");
    @(posedge mclk) {sys_rst, anDone, opMode, lpBasePage} <= {1'b0, 1'b1, 2'h1, 16'h0400};
    settle();
    chk(statusHi, expect_hi({2'h1, 16'h0400, 16'h0}), "after reset");
    chk(trustedHi, 8'h06, "sgmii trusted");
    $display("Reset and enable done");
    close_out();
  end
endmodule : arsv_status_hi_tb
